//--- port_b_defs.svh
// Purpose: register offsets, field positions and reset values of the port pad and pin interrupt block
// Assumes: byte-wide registers on a plain strobe port, one byte per index
// Notes: included by bare name; definitions only
`ifndef PORT_B_DEFS_SVH
`define PORT_B_DEFS_SVH

`define ADDR_W 4
`define PORT_W 8

`define OFF_DATA 4'h0
`define OFF_DIRECTION 4'h1
`define OFF_PULL_ENABLE 4'h2
`define OFF_SLEW_RATE 4'h3
`define OFF_DRIVE_STRENGTH 4'h4
`define OFF_STATUS_CONTROL 4'h5
`define OFF_IRQ_SELECT 4'h6
`define OFF_IRQ_POLARITY 4'h7
`define OFF_PIN_HIT_STATUS 4'h8
`define OFF_PIN_HIT_MASK 4'h9

`define SC_FLAG_BIT 3
`define SC_ACK_BIT 2
`define SC_ENABLE_BIT 1
`define SC_MODE_BIT 0

`define RESET_BYTE 8'h00
`define RESET_MASK 8'hff

`endif

//--- port_b_pkg.sv
// Purpose: shared types of the port pad and pin interrupt block
// Assumes: port_b_defs.svh gives the widths
// Notes: types only
`default_nettype none
`include "port_b_defs.svh"

package port_b_pkg;
  typedef logic [`PORT_W-1:0] port_byte_type;
  typedef logic [`ADDR_W-1:0] reg_addr_type;
  typedef enum logic {edge_only = 1'b0, edge_and_level = 1'b1} detect_mode_type;
endpackage

`default_nettype wire

//--- pin_edge_detect.sv
// Purpose: synchronise the port pins and find active edges and levels per pin
// Assumes: pins are asynchronous to core_clk
// Notes: active sense per pin follows the polarity bit
`default_nettype none
`include "port_b_defs.svh"

module pin_edge_detect
  import port_b_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // pins and polarity
  input wire port_byte_type pin_raw,
  input wire port_byte_type polarity,
  // results
  output port_byte_type pin_sync,
  output port_byte_type active_edge,
  output port_byte_type active_level
);
  port_byte_type meta;
  port_byte_type prev;
  wire port_byte_type rise = pin_sync & ~prev;
  wire port_byte_type fall = ~pin_sync & prev;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      meta <= `RESET_BYTE;
      pin_sync <= `RESET_BYTE;
      prev <= `RESET_BYTE;
    end
    else
    begin
      meta <= pin_raw; // RL15
      pin_sync <= meta; // RL15
      prev <= pin_sync; // RL15
    end
  end

  // polarity 0 looks for falling or low, 1 for rising or high
  assign active_edge = (polarity & rise) | (~polarity & fall); // RL11 RL12
  assign active_level = (polarity & pin_sync) | (~polarity & ~pin_sync); // RL11 RL12
endmodule

`default_nettype wire

//--- pad_control.sv
// Purpose: registered pad control outputs of the port
// Assumes: configuration registers held by the caller
// Notes: every output is a flip-flop
`default_nettype none
`include "port_b_defs.svh"

module pad_control
  import port_b_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // configuration
  input wire port_byte_type direction,
  input wire port_byte_type pull_enable,
  input wire port_byte_type slew_rate,
  input wire port_byte_type drive_strength,
  input wire port_byte_type irq_select,
  input wire port_byte_type irq_polarity,
  // pad controls
  output port_byte_type pull_up_en,
  output port_byte_type pull_down_en,
  output port_byte_type slew_limit_en,
  output port_byte_type high_drive_en
);
  // outputs kill the pull so a driven pin fights its own pull for at most one cycle
  wire port_byte_type pull_any = pull_enable & ~direction; // RL1 RL2 RL13
  wire port_byte_type pull_down_ok = irq_select & irq_polarity; // RL3
  wire port_byte_type next_pull_down = pull_any & pull_down_ok; // RL3 RL12
  wire port_byte_type next_pull_up = pull_any & ~pull_down_ok; // RL3 RL11
  wire port_byte_type next_slew = slew_rate & direction; // RL4
  wire port_byte_type next_drive = drive_strength & direction; // RL5

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pull_up_en <= `RESET_BYTE;
      pull_down_en <= `RESET_BYTE;
      slew_limit_en <= `RESET_BYTE;
      high_drive_en <= `RESET_BYTE;
    end
    else
    begin
      pull_up_en <= next_pull_up;
      pull_down_en <= next_pull_down;
      slew_limit_en <= next_slew;
      high_drive_en <= next_drive;
    end
  end
endmodule

`default_nettype wire

//--- port_b_pin_control.sv
// Purpose: 8-bit port with pad control and a pin interrupt unit behind a byte register port
// Assumes: one clock core_clk, synchronous reset srst, strobes one cycle long
// Notes: pad controls lag configuration writes by one cycle
//
// How it works
// RL1: pull enable bit switches pin pull device
// RL2: output pins always have pull disabled
// RL3: pull-down only for selected rising-polarity pins
// RL4: slew bit limits slew on outputs only
// RL5: drive bit selects high drive on outputs
// RL6: flag bit 3 set by detection, unwritable
// RL7: ack bit 2 clears flag, reads zero
// RL8: request only while flag and enable set
// RL9: mode bit 0 selects edge or level
// RL10: only selected pins take part in detection
// RL11: polarity 0 means pull-up, falling/low
// RL12: polarity 1 means pull-down, rising/high
// RL13: direction 1 enables the pin driver
// RL14: level-mode ack keeps flag while level active
// RL15: pins synchronised, edges from sample history
`default_nettype none
`include "port_b_defs.svh"

module port_b_pin_control
  import port_b_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire reg_addr_type reg_addr,
  input wire port_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output port_byte_type reg_rdata,
  // port pins
  input wire port_byte_type pin_in,
  output port_byte_type pin_out,
  output port_byte_type pin_oe,
  // pad controls
  output port_byte_type pull_up_en,
  output port_byte_type pull_down_en,
  output port_byte_type slew_limit_en,
  output port_byte_type high_drive_en,
  // interrupt
  output logic pin_irq
);
  port_byte_type data_bits;
  port_byte_type direction_bits;
  port_byte_type pull_enable_bits;
  port_byte_type slew_rate_bits;
  port_byte_type drive_strength_bits;
  port_byte_type pin_irq_select_bits;
  port_byte_type pin_irq_polarity_bits;
  port_byte_type pin_hit_status;
  port_byte_type pin_hit_mask;
  logic pin_irq_flag;
  logic pin_irq_enable;
  detect_mode_type detection_mode;
  port_byte_type pin_sync;
  port_byte_type active_edge;
  port_byte_type active_level;

  function automatic logic hit(input reg_addr_type a, input reg_addr_type off, input logic stb);
    hit = stb && (a == off);
  endfunction

  // write decode
  wire wr_data = hit(reg_addr, `OFF_DATA, reg_wr);
  wire wr_dir = hit(reg_addr, `OFF_DIRECTION, reg_wr);
  wire wr_pe = hit(reg_addr, `OFF_PULL_ENABLE, reg_wr);
  wire wr_se = hit(reg_addr, `OFF_SLEW_RATE, reg_wr);
  wire wr_ds = hit(reg_addr, `OFF_DRIVE_STRENGTH, reg_wr);
  wire wr_sc = hit(reg_addr, `OFF_STATUS_CONTROL, reg_wr);
  wire wr_ps = hit(reg_addr, `OFF_IRQ_SELECT, reg_wr);
  wire wr_es = hit(reg_addr, `OFF_IRQ_POLARITY, reg_wr);
  wire wr_hs = hit(reg_addr, `OFF_PIN_HIT_STATUS, reg_wr);
  wire wr_hm = hit(reg_addr, `OFF_PIN_HIT_MASK, reg_wr);

  // detection
  wire port_byte_type level_hits = pin_irq_select_bits & active_level; // RL10
  wire port_byte_type pin_hits = pin_irq_select_bits &
    (active_edge | ({`PORT_W{detection_mode == edge_and_level}} & active_level)); // RL9 RL10
  wire any_hit = |pin_hits;
  wire level_held = (detection_mode == edge_and_level) && (|level_hits); // RL14
  wire ack = wr_sc && reg_wdata[`SC_ACK_BIT]; // RL7
  // a detection in the acknowledge cycle wins so no event is lost
  wire next_flag = any_hit || level_held && ack || pin_irq_flag && !ack; // RL6 RL7 RL14
  wire port_byte_type next_hit_status = pin_hits |
    (pin_hit_status & ~({`PORT_W{wr_hs}} & reg_wdata));
  // the mask only narrows which pins can raise the request
  wire next_irq_enable = wr_sc ? reg_wdata[`SC_ENABLE_BIT] : pin_irq_enable;
  wire port_byte_type next_hit_mask = wr_hm ? reg_wdata : pin_hit_mask;
  wire next_irq = next_flag && next_irq_enable && (|(next_hit_status & next_hit_mask)); // RL8

  // read mux
  wire port_byte_type sc_read = {4'h0, pin_irq_flag, 1'b0, pin_irq_enable, detection_mode}; // RL6 RL7
  wire port_byte_type data_read = (data_bits & direction_bits) | (pin_sync & ~direction_bits);
  port_byte_type read_mux;
  always_comb
  begin
    unique case (reg_addr)
      `OFF_DATA: read_mux = data_read;
      `OFF_DIRECTION: read_mux = direction_bits;
      `OFF_PULL_ENABLE: read_mux = pull_enable_bits;
      `OFF_SLEW_RATE: read_mux = slew_rate_bits;
      `OFF_DRIVE_STRENGTH: read_mux = drive_strength_bits;
      `OFF_STATUS_CONTROL: read_mux = sc_read;
      `OFF_IRQ_SELECT: read_mux = pin_irq_select_bits;
      `OFF_IRQ_POLARITY: read_mux = pin_irq_polarity_bits;
      `OFF_PIN_HIT_STATUS: read_mux = pin_hit_status;
      `OFF_PIN_HIT_MASK: read_mux = pin_hit_mask;
      default: read_mux = `RESET_BYTE;
    endcase
  end

  pin_edge_detect detect_u (
    .core_clk(core_clk),
    .srst(srst),
    .pin_raw(pin_in),
    .polarity(pin_irq_polarity_bits),
    .pin_sync(pin_sync),
    .active_edge(active_edge),
    .active_level(active_level)
  );

  pad_control pad_u (
    .core_clk(core_clk),
    .srst(srst),
    .direction(direction_bits),
    .pull_enable(pull_enable_bits),
    .slew_rate(slew_rate_bits),
    .drive_strength(drive_strength_bits),
    .irq_select(pin_irq_select_bits),
    .irq_polarity(pin_irq_polarity_bits),
    .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en),
    .slew_limit_en(slew_limit_en),
    .high_drive_en(high_drive_en)
  );

  // configuration registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      data_bits <= `RESET_BYTE;
      direction_bits <= `RESET_BYTE;
      pull_enable_bits <= `RESET_BYTE;
      slew_rate_bits <= `RESET_BYTE;
      drive_strength_bits <= `RESET_BYTE;
      pin_irq_select_bits <= `RESET_BYTE;
      pin_irq_polarity_bits <= `RESET_BYTE;
      pin_hit_mask <= `RESET_MASK;
    end
    else
    begin
      if (wr_data) data_bits <= reg_wdata;
      if (wr_dir) direction_bits <= reg_wdata; // RL13
      if (wr_pe) pull_enable_bits <= reg_wdata; // RL1
      if (wr_se) slew_rate_bits <= reg_wdata; // RL4
      if (wr_ds) drive_strength_bits <= reg_wdata; // RL5
      if (wr_ps) pin_irq_select_bits <= reg_wdata; // RL10
      if (wr_es) pin_irq_polarity_bits <= reg_wdata; // RL11 RL12
      if (wr_hm) pin_hit_mask <= reg_wdata;
    end
  end

  // interrupt state
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_irq_flag <= 1'b0;
      pin_irq_enable <= 1'b0;
      detection_mode <= edge_only;
      pin_hit_status <= `RESET_BYTE;
      pin_irq <= 1'b0;
    end
    else
    begin
      pin_irq_flag <= next_flag; // RL6
      pin_irq_enable <= next_irq_enable; // RL8
      if (wr_sc) detection_mode <= detect_mode_type'(reg_wdata[`SC_MODE_BIT]); // RL9
      pin_hit_status <= next_hit_status;
      pin_irq <= next_irq; // RL8
    end
  end

  // pin drivers and read data
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pin_out <= `RESET_BYTE;
      pin_oe <= `RESET_BYTE;
      reg_rdata <= `RESET_BYTE;
    end
    else
    begin
      pin_out <= wr_data ? reg_wdata : data_bits;
      pin_oe <= wr_dir ? reg_wdata : direction_bits; // RL13
      reg_rdata <= reg_rd ? read_mux : `RESET_BYTE;
    end
  end
endmodule

`default_nettype wire

//--- pin_ctl_properties.sv
// Purpose: port-level checks of the pad and pin interrupt block
// Assumes: pads lag the config registers by one cycle
// Notes: enable bit shadowed from writes
`default_nettype none
`include "port_b_defs.svh"
module pin_ctl_checker
  import port_b_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // register port
  input wire reg_addr_type reg_addr,
  input wire port_byte_type reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire port_byte_type reg_rdata,
  // pads and interrupt
  input wire port_byte_type pin_oe,
  input wire port_byte_type pull_up_en,
  input wire port_byte_type pull_down_en,
  input wire port_byte_type slew_limit_en,
  input wire port_byte_type high_drive_en,
  input wire logic pin_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_en;
  wire sc_wr = reg_wr && reg_addr == `OFF_STATUS_CONTROL;
  always_ff @(posedge core_clk)
    if (srst)
      irq_en <= 1'b0;
    else if (sc_wr)
      irq_en <= reg_wdata[`SC_ENABLE_BIT];
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence s_irq_off;
    sc_wr && !reg_wdata[`SC_ENABLE_BIT];
  endsequence
  sequence s_sc_read;
    reg_rd && reg_addr == `OFF_STATUS_CONTROL;
  endsequence
  // pads follow the previous cycle's direction
  a_pull_out_off: assert property (((pull_up_en | pull_down_en) & $past(pin_oe)) == 8'h00)
    else $error("pull on output");
  a_pulls_exclusive: assert property ((pull_up_en & pull_down_en) == 8'h00)
    else $error("both pulls on");
  a_slew_out_only: assert property ((slew_limit_en & ~$past(pin_oe)) == 8'h00)
    else $error("slew on input");
  a_drive_out_only: assert property ((high_drive_en & ~$past(pin_oe)) == 8'h00)
    else $error("drive on input");
  a_dir_drives: assert property (reg_wr && reg_addr == `OFF_DIRECTION |=> pin_oe == $past(reg_wdata))
    else $error("direction not applied");
  a_ack_reads_zero: assert property (s_sc_read |=> reg_rdata[`SC_ACK_BIT] == 1'b0)
    else $error("ack bit read as one");
  a_irq_needs_enable: assert property (pin_irq |-> irq_en)
    else $error("request while disabled");
  a_irq_off_write: assert property (s_irq_off |=> !pin_irq)
    else $error("request after disable");
endmodule
bind port_b_pin_control pin_ctl_checker i_chk (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .pin_oe, .pull_up_en, .pull_down_en, .slew_limit_en, .high_drive_en, .pin_irq);
`default_nettype wire

//--- pin_pad_model.sv
// Purpose: external circuitry on the eight port pins
// Assumes: block drives when pin_oe set, else bench or pulls
// Notes: a bare pin wobbles each cycle, never a steady level
`default_nettype none
module pin_pad_model
  import port_b_pkg::*;
(
  // clock
  input wire logic core_clk,
  // pad state
  input wire port_byte_type pin_out,
  input wire port_byte_type pin_oe,
  input wire port_byte_type pull_up_en,
  input wire port_byte_type pull_down_en,
  // bench drivers
  input wire port_byte_type ext_val,
  input wire port_byte_type ext_drv,
  // pin levels
  output port_byte_type pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  port_byte_type wobble = 8'h00;
  always @(posedge core_clk)
    wobble <= ~wobble;
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
    | (~pin_oe & ~ext_drv & (pull_up_en | (~pull_down_en & wobble)));
endmodule
`default_nettype wire

//--- test_port_b_pin_control_and_interrupt.sv
// Purpose: register-driven test of pads and pin interrupt
// Assumes: read data one cycle after the strobe
// Notes: pins settle over six cycles between steps
`default_nettype none
module test_port_b_pin_control_and_interrupt
  import port_b_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  reg_addr_type reg_addr = 4'h0;
  port_byte_type reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  port_byte_type ext_val = 8'h00;
  port_byte_type ext_drv = 8'h00;
  port_byte_type reg_rdata, pin_in, pin_out, pin_oe, pu, pd, slew, drive;
  logic pin_irq;
  int err_total = 0;
  int checks = 0;
  always #10 core_clk = ~core_clk;
  port_b_pin_control i_dut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_in, .pin_out, .pin_oe, .pull_up_en(pu), .pull_down_en(pd), .slew_limit_en(slew),
    .high_drive_en(drive), .pin_irq);
  pin_pad_model i_pins (.core_clk, .pin_out, .pin_oe, .pull_up_en(pu), .pull_down_en(pd),
    .ext_val, .ext_drv, .pin_in);
  task automatic summarize();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input port_byte_type got, input port_byte_type exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input reg_addr_type a, input port_byte_type d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input reg_addr_type a, input port_byte_type e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // synchroniser plus edge stage need three edges; six is margin
  task automatic pins(input port_byte_type v);
    @(posedge core_clk);
    ext_val <= v;
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  task automatic wirq();
    int n;
    for (n = 0; n < 10 && pin_irq !== 1'b1; n++)
      @(posedge core_clk) #1;
    chk(pin_irq, 1'b1);
    if (n == 10)
      summarize();
  endtask
  initial
  begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    wr(4'ha, 8'hff);
    for (int i = 1; i < 11; i++)
      rd(i[3:0], i == 9 ? 8'hff : 8'h00);
    wr(4'h1, 8'h0f);
    wr(4'h2, 8'hff);
    wr(4'h3, 8'hff);
    wr(4'h4, 8'hff);
    wr(4'h7, 8'hc0);
    wr(4'h6, 8'hf0);
    wr(4'h0, 8'h55);
    pins(8'h00);
    chk(pin_oe, 8'h0f);
    chk(pu, 8'h30);
    chk(pd, 8'hc0);
    chk(slew, 8'h0f);
    chk(drive, 8'h0f);
    chk(pin_out, 8'h55);
    rd(4'h0, 8'h35);
    wr(4'h2, 8'h00);
    pins(8'h00);
    chk(pu | pd, 8'h00);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    ext_drv <= 8'hff;
    pins(8'hff);
    wr(4'h6, 8'h01);
    wr(4'h5, 8'h02);
    pins(8'hfd);
    rd(4'h5, 8'h02);
    pins(8'hfc);
    wirq();
    rd(4'h8, 8'h01);
    wr(4'h5, 8'h02);
    rd(4'h5, 8'h0a);
    wr(4'h5, 8'h06);
    chk(pin_irq, 1'b0);
    rd(4'h5, 8'h02);
    wr(4'h9, 8'h00);
    pins(8'hfd);
    pins(8'hfc);
    chk(pin_irq, 1'b0);
    wr(4'h9, 8'hff);
    wirq();
    wr(4'h8, 8'h01);
    chk(pin_irq, 1'b0);
    wr(4'h5, 8'h04);
    pins(8'hfd);
    pins(8'hfc);
    rd(4'h5, 8'h08);
    chk(pin_irq, 1'b0);
    wr(4'h6, 8'h00);
    wr(4'h7, 8'h01);
    wr(4'h6, 8'h01);
    wr(4'h5, 8'h06);
    pins(8'hfd);
    wirq();
    wr(4'h5, 8'h06);
    chk(pin_irq, 1'b0);
    wr(4'h5, 8'h03);
    wirq();
    wr(4'h5, 8'h07);
    rd(4'h5, 8'h0b);
    pins(8'hfc);
    wr(4'h5, 8'h07);
    rd(4'h5, 8'h03);
    summarize();
  end
endmodule
`default_nettype wire
